// >>> rtl/pmb_mailbox.sv
// Host-side mailbox registers with per-byte fill status shared with the add-on side
// Function
// R1 - Decode six operation registers in window
// R2 - Outside parties never access shared registers concurrently
// R3 - Host avoids undefined offsets in window
// R4 - Outgoing mailbox at 0Ch, host read/write
// R5 - Mailboxes accept byte, word, dword lanes
// R6 - Host outgoing write can raise add-on event
// R7 - Host outgoing read changes no status
// R8 - Incoming mailbox at 1Ch, host read-only
// R9 - Host incoming read can raise add-on event
// R10 - Incoming byte 3 loadable by external hardware
// R11 - Fill status at 34h, read-only, resets zero
// R12 - Bits 31:28 flag incoming bytes 3..0
// R13 - Bits 15:12 flag outgoing bytes 3..0
// R14 - Flag set on write, cleared on read
// R15 - Mailbox storage shared between both buses
// R16 - Bit 17 set by add-on write, W1C
// R17 - Bits 9:8 select byte, bit 12 enables
// R18 - Other fill status bits read zero
// R19 - Partial access touches only addressed lane flags
`timescale 1ns/1ps
`include "pmb_params.svh"
module pmb_mailbox (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] host_addr,
  input wire logic [3:0] host_be,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_rvalid,
  output logic host_mbox_irq,
  input wire logic [3:0] addon_be,
  input wire logic addon_wr,
  input wire logic addon_rd,
  input wire logic [31:0] addon_wdata,
  output logic [31:0] addon_rdata,
  output logic addon_rvalid,
  output logic [31:0] addon_fill_status,
  input wire logic addon_wr_event_en,
  input wire logic addon_rd_event_en,
  output logic addon_mbox_event,
  input wire logic ext_byte3_load,
  input wire logic [7:0] ext_byte3_data
);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] fill_word(input logic [3:0] in_f, input logic [3:0] out_f);
    logic [31:0] res;
    res = `PMB_FILL_RESET;
    res[`PMB_FILL_IN_LSB +: 4] = in_f;
    res[`PMB_FILL_OUT_LSB +: 4] = out_f;
    return res;
  endfunction

  // ==========================================================================
  // External byte-3 load, synchronised then edge detected
  logic [8:0] ext_sync;
  logic ext_load;

  pmb_sync u_pmb_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({ext_byte3_load, ext_byte3_data}),
    .sync_out(ext_sync)
  );

  // ==========================================================================
  // State
  pmb_pkg::pmb_state_t st_reg;
  pmb_pkg::pmb_state_t st_next;

  logic hit_out;
  logic hit_in;
  logic hit_fill;
  logic hit_int;
  logic hit_other;
  logic [3:0] out_wr_lanes;
  logic [3:0] out_rd_lanes;
  logic [3:0] in_wr_lanes;
  logic [3:0] in_rd_lanes;
  logic irq_clear;
  logic irq_set;
  logic [31:0] int_word;

  assign ext_load = ext_sync[8] && !st_reg.ext_prev;

  // Six operation registers decoded; reset control and pass-thru read as zero here
  assign hit_out = (host_addr == `PMB_OFS_OUTGOING);  // see R1
  assign hit_in = (host_addr == `PMB_OFS_INCOMING);
  assign hit_fill = (host_addr == `PMB_OFS_FILL);
  assign hit_int = (host_addr == `PMB_OFS_INTCTL);
  assign hit_other = (host_addr == `PMB_OFS_RESETCTL) || (host_addr == `PMB_OFS_PASSTHRU);

  assign out_wr_lanes = (host_wr && hit_out) ? host_be : 4'h0;  // see R19
  assign out_rd_lanes = addon_rd ? addon_be : 4'h0;
  assign in_wr_lanes = (addon_wr ? addon_be : 4'h0) | {ext_load, 3'h0};  // see R10
  assign in_rd_lanes = (host_rd && hit_in) ? host_be : 4'h0;  // see R19

  assign irq_clear = host_wr && hit_int && host_be[2] && host_wdata[`PMB_INT_FLAG_BIT];  // see R16
  assign irq_set = st_reg.irq_en && in_wr_lanes[st_reg.irq_sel];  // see R17

  always_comb begin
    int_word = `PMB_INTCTL_RESET;
    int_word[`PMB_INT_FLAG_BIT] = st_reg.irq_flag;
    int_word[`PMB_INT_EN_BIT] = st_reg.irq_en;
    int_word[`PMB_INT_SEL_LSB +: 2] = st_reg.irq_sel;
  end

  always_comb begin
    st_next = st_reg;
    st_next.host_rvalid = 1'b0;
    st_next.addon_rvalid = 1'b0;
    st_next.ext_prev = ext_sync[8];
    // One storage word per direction, seen from both buses
    if (host_wr && hit_out) begin
      st_next.outgoing = lane_merge(st_reg.outgoing, host_wdata, host_be);  // see R4, R5, R15
    end
    if (addon_wr) begin
      st_next.incoming = lane_merge(st_reg.incoming, addon_wdata, addon_be);  // see R8, R15
    end
    // Pin load lands after the bus write so the hardware path wins a same-cycle clash
    if (ext_load) begin
      st_next.incoming[31:24] = ext_sync[7:0];  // see R10
    end
    // Set wins over clear; a same-cycle clash is excluded by the users anyway
    st_next.out_full = (st_reg.out_full & ~out_rd_lanes) | out_wr_lanes;  // see R13, R14
    st_next.in_full = (st_reg.in_full & ~in_rd_lanes) | in_wr_lanes;  // see R12, R14
    if (irq_set) begin
      st_next.irq_flag = 1'b1;  // see R16
    end else if (irq_clear) begin
      st_next.irq_flag = 1'b0;
    end
    if (host_wr && hit_int && host_be[1]) begin
      st_next.irq_en = host_wdata[`PMB_INT_EN_BIT];  // see R17
      st_next.irq_sel = host_wdata[`PMB_INT_SEL_LSB +: 2];
    end
    // Host read path; unmapped and unimplemented offsets return zero
    if (host_rd) begin
      st_next.host_rvalid = 1'b1;
      if (hit_out) begin
        st_next.host_rdata = st_reg.outgoing;  // see R7
      end else if (hit_in) begin
        st_next.host_rdata = st_reg.incoming;  // see R5
      end else if (hit_fill) begin
        st_next.host_rdata = fill_word(st_reg.in_full, st_reg.out_full);  // see R11, R18
      end else if (hit_int) begin
        st_next.host_rdata = int_word;
      end else if (hit_other) begin
        st_next.host_rdata = 32'h00000000;
      end else begin
        st_next.host_rdata = 32'h00000000;
      end
    end
    if (addon_rd) begin
      st_next.addon_rvalid = 1'b1;
      st_next.addon_rdata = st_reg.outgoing;  // see R15
    end
    st_next.addon_event = ((out_wr_lanes != 4'h0) && addon_wr_event_en) ||
                          ((in_rd_lanes != 4'h0) && addon_rd_event_en);  // see R6, R9
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.irq_sel <= 2'h0;
      st_reg.outgoing <= `PMB_MBOX_RESET;
      st_reg.incoming <= `PMB_MBOX_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_rdata = st_reg.host_rdata;
  assign host_rvalid = st_reg.host_rvalid;
  assign host_mbox_irq = st_reg.irq_flag;
  assign addon_rdata = st_reg.addon_rdata;
  assign addon_rvalid = st_reg.addon_rvalid;
  assign addon_fill_status = fill_word(st_reg.in_full, st_reg.out_full);
  assign addon_mbox_event = st_reg.addon_event;

  // ==========================================================================
  // Checks
  chk_outgoing_dword: assert property (@(posedge mclk) disable iff (!rstn)  // see R4
    (host_wr && hit_out && host_be == 4'hF) |=> (st_reg.outgoing == $past(host_wdata)))
    else $error("outgoing mailbox did not take a full write");

  chk_out_flag_set: assert property (@(posedge mclk) disable iff (!rstn)  // see R13
    (host_wr && hit_out && host_be[0]) |=> st_reg.out_full[0])
    else $error("outgoing byte 0 flag not set by host write");

  chk_out_flag_clear: assert property (@(posedge mclk) disable iff (!rstn)  // see R14
    (addon_rd && addon_be[0] && !(host_wr && hit_out && host_be[0])) |=> !st_reg.out_full[0])
    else $error("outgoing byte 0 flag not cleared by add-on read");

  chk_in_flag_set: assert property (@(posedge mclk) disable iff (!rstn)  // see R12
    (addon_wr && addon_be[3]) |=> st_reg.in_full[3])
    else $error("incoming byte 3 flag not set by add-on write");

  chk_in_lane_only: assert property (@(posedge mclk) disable iff (!rstn)  // see R19
    (host_rd && hit_in && host_be == 4'h4 && !addon_wr && !ext_load)
      |=> (st_reg.in_full == ($past(st_reg.in_full) & 4'hB)))
    else $error("host read of byte 2 touched other flags");

  chk_read_keeps: assert property (@(posedge mclk) disable iff (!rstn)  // see R7
    (host_rd && hit_out && !addon_rd && !addon_wr && !ext_load)
      |=> ($stable(st_reg.out_full) && $stable(st_reg.in_full) && $stable(st_reg.irq_flag)))
    else $error("host outgoing read changed status");

  chk_irq_raise: assert property (@(posedge mclk) disable iff (!rstn)  // see R17
    (addon_wr && st_reg.irq_en && addon_be[st_reg.irq_sel]) |=> ##[0:2] host_mbox_irq)
    else $error("incoming interrupt not raised for selected byte");

  chk_irq_w1c: assert property (@(posedge mclk) disable iff (!rstn)  // see R16
    (irq_clear && !irq_set) |=> !host_mbox_irq)
    else $error("interrupt flag not cleared by write one");

  chk_fill_read: assert property (@(posedge mclk) disable iff (!rstn)  // see R11
    (host_rd && hit_fill) |=> (host_rvalid && host_rdata[27:16] == 12'h000 && host_rdata[11:0] == 12'h000
      && host_rdata[31:28] == $past(st_reg.in_full) && host_rdata[15:12] == $past(st_reg.out_full)))
    else $error("fill status read wrong");

  chk_addon_event: assert property (@(posedge mclk) disable iff (!rstn)  // see R6
    (host_wr && hit_out && host_be != 4'h0 && addon_wr_event_en) |=> addon_mbox_event)
    else $error("add-on event missing after host write");

  chk_ext_byte3: assert property (@(posedge mclk) disable iff (!rstn)  // see R10
    ext_load |=> (st_reg.incoming[31:24] == $past(ext_sync[7:0]) && st_reg.in_full[3]))
    else $error("external byte 3 load lost");

endmodule

// >>> rtl/pmb_params.svh
// Offsets, field positions and reset values of the host mailbox register block
`ifndef PMB_PARAMS_SVH
`define PMB_PARAMS_SVH

// ==========================================================================
// Register offsets inside the base address zero window
`define PMB_OFS_OUTGOING 8'h0C
`define PMB_OFS_INCOMING 8'h1C
`define PMB_OFS_FILL 8'h34
`define PMB_OFS_INTCTL 8'h38
`define PMB_OFS_RESETCTL 8'h3C
`define PMB_OFS_PASSTHRU 8'h60

// ==========================================================================
// Field positions
`define PMB_FILL_IN_LSB 28
`define PMB_FILL_OUT_LSB 12
`define PMB_INT_FLAG_BIT 17
`define PMB_INT_EN_BIT 12
`define PMB_INT_SEL_LSB 8

// ==========================================================================
// Reset values
`define PMB_FILL_RESET 32'h00000000
`define PMB_INTCTL_RESET 32'h00000C0C
`define PMB_MBOX_RESET 32'h00000000

`endif

// >>> rtl/pmb_pkg.sv
// Types shared by the host mailbox register block
package pmb_pkg;

  // ==========================================================================
  // Synchroniser state
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
  } pmb_sync_t;

  // ==========================================================================
  // Mailbox block state
  typedef struct packed {
    logic [31:0] outgoing;
    logic [31:0] incoming;
    logic [3:0] out_full;
    logic [3:0] in_full;
    logic irq_flag;
    logic irq_en;
    logic [1:0] irq_sel;
    logic [31:0] host_rdata;
    logic host_rvalid;
    logic [31:0] addon_rdata;
    logic addon_rvalid;
    logic addon_event;
    logic ext_prev;
  } pmb_state_t;

endpackage

// >>> rtl/pmb_sync.sv
// Two-stage synchroniser for the external byte-3 load pins
`timescale 1ns/1ps
module pmb_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [8:0] async_in,
  output logic [8:0] sync_out
);

  pmb_pkg::pmb_sync_t st_reg;
  pmb_pkg::pmb_sync_t st_next;

  always_comb begin
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;

endmodule

// >>> verif/pmb_addon_model.sv
// Add-on side model: drives the add-on mailbox port and the byte-3 load pins
`timescale 1ns/1ps
module pmb_addon_model (
  input wire logic mclk,
  output logic [3:0] addon_be,
  output logic addon_wr,
  output logic addon_rd,
  output logic [31:0] addon_wdata,
  input wire logic [31:0] addon_rdata,
  output logic ext_byte3_load,
  output logic [7:0] ext_byte3_data
);
  initial begin
    addon_be = 4'h0;
    addon_wr = 1'b0;
    addon_rd = 1'b0;
    addon_wdata = 32'h00000000;
    ext_byte3_load = 1'b0;
    ext_byte3_data = 8'h00;
  end
  // ==========================================================================
  // Bus cycles, never overlapping a host access to the same register
  task automatic aw(input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    addon_be <= be;
    addon_wdata <= d;
    addon_wr <= 1'b1;
    @(posedge mclk);
    addon_wr <= 1'b0;
    // Released bus shows the inverse so a stale value cannot pass
    addon_wdata <= ~d;
  endtask
  task automatic ar(input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk);
    addon_be <= be;
    addon_rd <= 1'b1;
    @(posedge mclk);
    addon_rd <= 1'b0;
    #1;
    q = addon_rdata;
  endtask
  // Pin pulse held long enough for the two-flop sync; data held past it
  task automatic ext(input logic [7:0] d);
    @(posedge mclk);
    ext_byte3_data <= d;
    @(posedge mclk);
    ext_byte3_load <= 1'b1;
    repeat (4) @(posedge mclk);
    ext_byte3_load <= 1'b0;
    repeat (3) @(posedge mclk);
    ext_byte3_data <= ~d;
  endtask
endmodule

// >>> verif/pci_mailbox_registers_tb_top.sv
// Self-checking bench for the host mailbox register block
`timescale 1ns/1ps
module pci_mailbox_registers_tb_top;
  logic mclk, rstn, host_wr, host_rd, host_rvalid, host_mbox_irq, wr_ev, rd_ev;
  logic addon_wr, addon_rd, addon_rvalid, addon_mbox_event, ext_byte3_load, ev;
  logic [7:0] host_addr, ext_byte3_data;
  logic [3:0] host_be, addon_be;
  logic [31:0] host_wdata, host_rdata, addon_wdata, addon_rdata, addon_fill_status, q;
  int n_fail = 0;
  int tests_run = 0;

  pmb_mailbox u_pmb_mailbox (.mclk(mclk), .rstn(rstn), .host_addr(host_addr), .host_be(host_be),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .host_mbox_irq(host_mbox_irq), .addon_be(addon_be), .addon_wr(addon_wr),
    .addon_rd(addon_rd), .addon_wdata(addon_wdata), .addon_rdata(addon_rdata), .addon_rvalid(addon_rvalid),
    .addon_fill_status(addon_fill_status), .addon_wr_event_en(wr_ev), .addon_rd_event_en(rd_ev),
    .addon_mbox_event(addon_mbox_event), .ext_byte3_load(ext_byte3_load), .ext_byte3_data(ext_byte3_data));
  pmb_addon_model u_addon (.mclk(mclk), .addon_be(addon_be), .addon_wr(addon_wr), .addon_rd(addon_rd),
    .addon_wdata(addon_wdata), .addon_rdata(addon_rdata), .ext_byte3_load(ext_byte3_load),
    .ext_byte3_data(ext_byte3_data));

  // ==========================================================================
  // Clock, reset and watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #20000;
    n_fail++;
    close_out();
  end

  // ==========================================================================
  // Host port cycles and comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hw(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_be <= be;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
    #1;
    ev = addon_mbox_event;
  endtask
  // Only the addressed lanes are compared
  task automatic rc(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp, input string what);
    logic [31:0] m;
    @(posedge mclk);
    host_addr <= a;
    host_be <= be;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1;
    ev = addon_mbox_event;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    chk({31'h0, host_rvalid}, 32'h1, "rvalid");
    chk(host_rdata & m, exp & m, what);
  endtask
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    rstn = 1'b0;
    host_addr = 8'h00;
    host_be = 4'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 32'h00000000;
    wr_ev = 1'b1;
    rd_ev = 1'b1;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rc(8'h34, 4'hF, 32'h00000000, "fill reset");
    rc(8'h38, 4'hF, 32'h00000C0C, "intctl reset");
    rc(8'h3C, 4'hF, 32'h00000000, "reset control");
    hw(8'h0C, 4'hF, 32'hA1B2C3D4);
    chk({31'h0, ev}, 32'h1, "write event");
    rc(8'h34, 4'hF, 32'h0000F000, "out flags");
    rc(8'h0C, 4'hF, 32'hA1B2C3D4, "out readback");
    chk({31'h0, ev}, 32'h0, "out read event");
    rc(8'h34, 4'hF, 32'h0000F000, "flags after out read");
    u_addon.ar(4'h3, q);
    chk(q, 32'hA1B2C3D4, "addon sees out");
    chk({31'h0, addon_rvalid}, 32'h1, "addon rvalid");
    chk(addon_fill_status, 32'h0000C000, "addon fill view");
    rc(8'h34, 4'hF, 32'h0000C000, "lane clear");
    hw(8'h0C, 4'h1, 32'h00000055);
    rc(8'h0C, 4'hF, 32'hA1B2C355, "byte write");
    rc(8'h34, 4'hF, 32'h0000D000, "lane set");
    @(posedge mclk);
    wr_ev <= 1'b0;
    hw(8'h0C, 4'h2, 32'h00006600);
    chk({31'h0, ev}, 32'h0, "event masked");
    hw(8'h38, 4'h2, 32'h00001300);
    u_addon.aw(4'hF, 32'h11223344);
    #1;
    chk({31'h0, host_mbox_irq}, 32'h1, "irq set");
    rc(8'h34, 4'hF, 32'hF000F000, "in flags");
    rc(8'h1C, 4'h4, 32'h11223344, "in byte read");
    chk({31'h0, ev}, 32'h1, "in read event");
    rc(8'h34, 4'hF, 32'hB000F000, "in lane clear");
    hw(8'h38, 4'h4, 32'h00000000);
    chk({31'h0, host_mbox_irq}, 32'h1, "write 0 keeps");
    hw(8'h38, 4'h4, 32'h00020000);
    chk({31'h0, host_mbox_irq}, 32'h0, "write 1 clears");
    u_addon.aw(4'h1, 32'h000000EE);
    #1;
    chk({31'h0, host_mbox_irq}, 32'h0, "unselected byte");
    hw(8'h1C, 4'hF, 32'h00000000);
    rc(8'h1C, 4'hF, 32'h112233EE, "in read-only");
    hw(8'h34, 4'hF, 32'hFFFFFFFF);
    rc(8'h34, 4'hF, 32'h0000F000, "fill read-only");
    u_addon.ext(8'h9C);
    chk({31'h0, host_mbox_irq}, 32'h1, "selected byte");
    rc(8'h34, 4'hF, 32'h8000F000, "ext flag");
    rc(8'h1C, 4'h8, 32'h9C000000, "ext byte");
    close_out();
  end
endmodule
